// [asc_channel.v]
// One asynchronous serial channel with registers, modem control and loop.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "asc_defs.vh"
// Summary of operation
// - Frame is start bit, five to eight data bits, optional parity, 1-2 stop.
// - Transmitter sends even, odd, forced or no parity as line control picks.
// - Break request holds the serial output low while its bit stays set, outside diagnostic mode.
// - With parity and sticky set, send inverse of even select as parity.
// - Forced parity receive checks against inverse even select, flags error.
// - Parity disabled means sticky bit ignored and no parity bit at all.
// - Written data goes to holding buffer, then shift register, then out.
// - Both transmit empty flags set after reset; a data write clears both.
// - Transfer sets holding free; finishing the shift sets idle unless refilled.
// - Receiver uses the same format and flags parity mismatches.
// - Receiver flags break when its input stays low over a frame time.
// - Missing stop bit sets the framing error flag.
// - New character over an unread one sets the overrun flag.
// - Only data bits move from receive shift register to receive buffer.
// - Reset clears receive full and all four receive error flags.
// - Per character: error flags, buffer, overrun and full flag all load in the same cycle.
// - Data read clears full, parity, framing, break; status read clears overrun.
// - DMA receive request is blocked while any receive error is flagged.
// - Unmasked receive full feeds the interrupt when its enable is set.
// - Internal modem link: clear follows request, ready and carrier follow dtr.
// - Status shows each modem input level and whether it has changed.
// - Diagnostic mode: output high, loop transmit to receive, modem looped.
// - Baud divider divides by 1 to 65536 (a divisor of zero gives 65536), giving a tick at sixteen times rate.
// - Receiver samples each bit in the middle of its period.
module asc_channel #(
    parameter DIV_W = 16
) (
    input  wire       mclk,
    input  wire       srst,
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       serial_in,
    output reg        serial_out,
    input  wire       clear_to_send_in_n,
    input  wire       set_ready_in_n,
    input  wire       carrier_detect_in_n,
    input  wire       call_alert_in_n,
    output reg        terminal_ready_out_n,
    output reg        request_to_send_out_n,
    output wire       rx_full_dma_req,
    output wire       rx_full_irq_src,
    output wire       tx_empty_dma_req,
    output wire       channel_irq
);
    localparam ST_IDLE = 3'd0;
    localparam ST_STRT = 3'd1;
    localparam ST_DATA = 3'd2;
    localparam ST_PAR  = 3'd3;
    localparam ST_STOP = 3'd4;
    localparam ST_BRKW = 3'd5;

    // Parity bit for a character of 5 + wl bits.
    function par_calc;
        input [7:0] d;
        input [1:0] wl;
        input       sp;
        input       even_parity_select;
        reg   [7:0] m;
        begin
            m = d & (8'hff >> (2'd3 - wl));
            if (sp)
                par_calc = ~even_parity_select;
            else
                par_calc = even_parity_select ? (^m) : ~(^m);
        end
    endfunction

    reg [7:0]       irq_en_reg;
    reg [7:0]       line_ctl_reg;
    reg [7:0]       modem_ctl_reg;
    reg [7:0]       channel_config_reg;
    reg [DIV_W-1:0] div_reg;
    reg [7:0]       tx_hold_reg;
    reg             hold_full_reg;
    reg             tx_idle_flag;
    reg [7:0]       tx_sh_reg;
    reg             tx_par_reg;
    reg [2:0]       tx_st_reg;
    reg [3:0]       tx_cnt_reg;
    reg [2:0]       tx_bit_reg;
    reg             tx_stop2_reg;
    reg [7:0]       rx_buf_reg;
    reg             rx_holding_valid;
    reg             overrun_reg;
    reg             parity_fault;
    reg             stop_bit_fault;
    reg             line_break_flag;
    reg [7:0]       rx_sh_reg;
    reg             rx_par_reg;
    reg             rx_zero_reg;
    reg [2:0]       rx_st_reg;
    reg [3:0]       rx_cnt_reg;
    reg [2:0]       rx_bit_reg;
    reg [3:0]       mdm_prev_reg;
    reg [3:0]       mdm_delta_reg;
    wire            tick16;

    wire [1:0] wlen   = line_ctl_reg[`ASC_LC_WLEN_HI:`ASC_LC_WLEN_LO];
    wire [2:0] lastb  = {1'b0, wlen} + 3'd4;
    wire       parity_enable    = line_ctl_reg[`ASC_LC_PEN];
    wire       sp_on  = parity_enable & line_ctl_reg[`ASC_LC_SP];
    wire       even_parity_select    = line_ctl_reg[`ASC_LC_EPS];
    wire       diag   = modem_ctl_reg[`ASC_MC_DIAG];
    wire       intmdm = channel_config_reg[`ASC_CFG_INTMODEM];
    wire       wr_tx  = reg_wr & (reg_addr == `ASC_OFS_DATA);
    wire       rd_rx  = reg_rd & (reg_addr == `ASC_OFS_DATA);
    wire       rd_ls  = reg_rd & (reg_addr == `ASC_OFS_LINE_STAT);
    wire       rd_ms  = reg_rd & (reg_addr == `ASC_OFS_MODEM_STA);

    asc_baud #(
        .DIV_W (DIV_W)
    ) u_baud (
        .mclk    (mclk),
        .srst    (srst),
        .divisor (div_reg),
        .tick16  (tick16)
    );

    always @(posedge mclk) begin
        if (srst) begin
            irq_en_reg         <= `ASC_IE_RST;
            line_ctl_reg       <= `ASC_LC_RST;
            modem_ctl_reg      <= `ASC_MC_RST;
            channel_config_reg <= `ASC_CFG_RST;
            div_reg            <= `ASC_DIV_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                `ASC_OFS_IRQ_EN:    irq_en_reg <= reg_wdata;
                `ASC_OFS_LINE_CTL:  line_ctl_reg <= reg_wdata;
                `ASC_OFS_MODEM_CTL: modem_ctl_reg <= reg_wdata;
                `ASC_OFS_CHAN_CFG:  channel_config_reg <= reg_wdata;
                `ASC_OFS_DIV_LO:    div_reg[7:0] <= reg_wdata;
                `ASC_OFS_DIV_HI:    div_reg[DIV_W-1:8] <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Transmit line level before break and diagnostic overrides.
    reg tx_line;
    always @* begin
        case (tx_st_reg)
            ST_STRT: tx_line = 1'b0;
            ST_DATA: tx_line = tx_sh_reg[0];
            ST_PAR:  tx_line = tx_par_reg;
            default: tx_line = 1'b1;
        endcase
    end

    wire tx_load = (tx_st_reg == ST_IDLE) & hold_full_reg;
    wire tx_bend = tick16 & (tx_cnt_reg == `ASC_TICK_LAST);
    wire tx_done = tx_bend & (tx_st_reg == ST_STOP) & ~tx_stop2_reg;

    always @(posedge mclk) begin
        if (srst) begin
            tx_hold_reg   <= 8'h00;
            hold_full_reg <= 1'b0;
            tx_idle_flag  <= 1'b1;
        end else begin
            if (wr_tx)
                tx_hold_reg <= reg_wdata;
            if (wr_tx)
                hold_full_reg <= 1'b1;
            else if (tx_load)
                hold_full_reg <= 1'b0;
            if (wr_tx)
                tx_idle_flag <= 1'b0;
            else if (tx_done & ~hold_full_reg)
                tx_idle_flag <= 1'b1;
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            tx_st_reg    <= ST_IDLE;
            tx_sh_reg    <= 8'h00;
            tx_par_reg   <= 1'b1;
            tx_cnt_reg   <= 4'h0;
            tx_bit_reg   <= 3'd0;
            tx_stop2_reg <= 1'b0;
        end else begin
            if (tick16)
                tx_cnt_reg <= tx_cnt_reg + 4'h1;
            case (tx_st_reg)
                ST_IDLE: begin
                    if (tx_load) begin
                        tx_sh_reg  <= tx_hold_reg;
                        tx_par_reg <= par_calc(tx_hold_reg, wlen,
                                               sp_on, even_parity_select);
                        tx_st_reg  <= ST_STRT;
                        tx_cnt_reg <= 4'h0;
                        tx_bit_reg <= 3'd0;
                    end
                end
                ST_STRT: begin
                    if (tx_bend)
                        tx_st_reg <= ST_DATA;
                end
                ST_DATA: begin
                    if (tx_bend) begin
                        tx_sh_reg  <= {1'b0, tx_sh_reg[7:1]};
                        tx_bit_reg <= tx_bit_reg + 3'd1;
                        if (tx_bit_reg == lastb) begin
                            tx_st_reg <= parity_enable ? ST_PAR : ST_STOP;
                            tx_stop2_reg <= line_ctl_reg[`ASC_LC_STOP2];
                        end
                    end
                end
                ST_PAR: begin
                    if (tx_bend)
                        tx_st_reg <= ST_STOP;
                end
                ST_STOP: begin
                    if (tx_bend) begin
                        tx_stop2_reg <= 1'b0;
                        if (!tx_stop2_reg)
                            tx_st_reg <= ST_IDLE;
                    end
                end
                default: tx_st_reg <= ST_IDLE;
            endcase
        end
    end

    // Break holds the line low only while software keeps the bit set, so
    // the caller times it to exceed one frame.
    always @(posedge mclk) begin
        if (srst)
            serial_out <= 1'b1;
        else if (diag)
            serial_out <= 1'b1;
        else if (line_ctl_reg[`ASC_LC_BREAK])
            serial_out <= 1'b0;
        else
            serial_out <= tx_line;
    end

    wire rx_src  = diag ? tx_line : serial_in;
    wire rx_mid  = tick16 & (rx_cnt_reg == `ASC_TICK_MID);
    wire rx_samp = tick16 & (rx_cnt_reg == `ASC_TICK_LAST);
    wire rx_done = rx_samp & (rx_st_reg == ST_STOP);
    wire pe_now  = parity_enable & (rx_par_reg !=
                   par_calc(rx_sh_reg, wlen, sp_on, even_parity_select));
    wire fe_now  = ~rx_src;
    wire bi_now  = rx_zero_reg & ~rx_src;

    always @(posedge mclk) begin
        if (srst) begin
            rx_st_reg   <= ST_IDLE;
            rx_cnt_reg  <= 4'h0;
            rx_bit_reg  <= 3'd0;
            rx_sh_reg   <= 8'h00;
            rx_par_reg  <= 1'b0;
            rx_zero_reg <= 1'b0;
        end else begin
            if (tick16)
                rx_cnt_reg <= rx_cnt_reg + 4'h1;
            case (rx_st_reg)
                ST_IDLE: begin
                    if (tick16 & ~rx_src) begin
                        rx_st_reg  <= ST_STRT;
                        rx_cnt_reg <= 4'h1;
                    end
                end
                ST_STRT: begin
                    // Realigning here makes later samples land mid-bit.
                    if (rx_mid) begin
                        rx_cnt_reg  <= 4'h0;
                        rx_bit_reg  <= 3'd0;
                        rx_sh_reg   <= 8'h00;
                        rx_zero_reg <= 1'b1;
                        rx_st_reg   <= rx_src ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (rx_samp) begin
                        rx_sh_reg[rx_bit_reg] <= rx_src;
                        rx_zero_reg <= rx_zero_reg & ~rx_src;
                        rx_bit_reg  <= rx_bit_reg + 3'd1;
                        if (rx_bit_reg == lastb)
                            rx_st_reg <= parity_enable ? ST_PAR : ST_STOP;
                    end
                end
                ST_PAR: begin
                    if (rx_samp) begin
                        rx_par_reg  <= rx_src;
                        rx_zero_reg <= rx_zero_reg & ~rx_src;
                        rx_st_reg   <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (rx_samp)
                        rx_st_reg <= rx_src ? ST_IDLE : ST_BRKW;
                end
                ST_BRKW: begin
                    if (tick16 & rx_src)
                        rx_st_reg <= ST_IDLE;
                end
                default: rx_st_reg <= ST_IDLE;
            endcase
        end
    end

    // A new character wins over a same-cycle clear from a read.
    always @(posedge mclk) begin
        if (srst) begin
            rx_buf_reg       <= 8'h00;
            rx_holding_valid <= 1'b0;
            overrun_reg      <= 1'b0;
            parity_fault     <= 1'b0;
            stop_bit_fault   <= 1'b0;
            line_break_flag  <= 1'b0;
        end else if (rx_done) begin
            parity_fault     <= pe_now;
            stop_bit_fault   <= fe_now;
            line_break_flag  <= bi_now;
            rx_buf_reg       <= rx_sh_reg;
            if (rx_holding_valid & ~rd_rx)
                overrun_reg <= 1'b1;
            else if (rd_ls)
                overrun_reg <= 1'b0;
            rx_holding_valid <= 1'b1;
        end else begin
            if (rd_rx) begin
                rx_holding_valid <= 1'b0;
                parity_fault     <= 1'b0;
                stop_bit_fault   <= 1'b0;
                line_break_flag  <= 1'b0;
            end
            if (rd_ls)
                overrun_reg <= 1'b0;
        end
    end

    // Modem inputs as asserted-high levels: cts, dsr, ri, dcd.
    reg [3:0] mdm_now;
    always @*
        if (diag)
            mdm_now = {modem_ctl_reg[`ASC_MC_OUT2],
                       modem_ctl_reg[`ASC_MC_OUT1],
                       modem_ctl_reg[`ASC_MC_DTR],
                       modem_ctl_reg[`ASC_MC_RTS]};
        else if (intmdm)
            mdm_now = {modem_ctl_reg[`ASC_MC_DTR], 1'b0,
                       modem_ctl_reg[`ASC_MC_DTR],
                       modem_ctl_reg[`ASC_MC_RTS]};
        else
            mdm_now = ~{carrier_detect_in_n, call_alert_in_n,
                        set_ready_in_n, clear_to_send_in_n};

    wire [3:0] mdm_chg = mdm_now ^ mdm_prev_reg;

    always @(posedge mclk) begin
        if (srst) begin
            mdm_prev_reg  <= 4'h0;
            mdm_delta_reg <= 4'h0;
        end else begin
            mdm_prev_reg  <= mdm_now;
            if (rd_ms)
                mdm_delta_reg <= mdm_chg;
            else
                mdm_delta_reg <= mdm_delta_reg | mdm_chg;
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            terminal_ready_out_n  <= 1'b1;
            request_to_send_out_n <= 1'b1;
        end else begin
            terminal_ready_out_n  <= diag |
                                     ~modem_ctl_reg[`ASC_MC_DTR];
            request_to_send_out_n <= diag |
                                     ~modem_ctl_reg[`ASC_MC_RTS];
        end
    end

    wire rx_err = overrun_reg | parity_fault | stop_bit_fault |
                  line_break_flag;
    wire [7:0] line_status = {1'b0, tx_idle_flag, ~hold_full_reg,
                              line_break_flag, stop_bit_fault,
                              parity_fault, overrun_reg,
                              rx_holding_valid};

    assign rx_full_dma_req  = rx_holding_valid & ~rx_err;
    assign rx_full_irq_src  = rx_holding_valid;
    assign tx_empty_dma_req = ~hold_full_reg;
    assign channel_irq = (irq_en_reg[`ASC_IE_RXDATA] & rx_full_irq_src) |
                         (irq_en_reg[`ASC_IE_TXFREE] & ~hold_full_reg) |
                         (irq_en_reg[`ASC_IE_LINE] & rx_err) |
                         (irq_en_reg[`ASC_IE_MODEM] &
                          (|mdm_delta_reg));

    always @(posedge mclk) begin
        if (srst)
            reg_rdata <= 8'h00;
        else if (reg_rd) begin
            case (reg_addr)
                `ASC_OFS_DATA:      reg_rdata <= rx_buf_reg;
                `ASC_OFS_IRQ_EN:    reg_rdata <= irq_en_reg;
                `ASC_OFS_LINE_CTL:  reg_rdata <= line_ctl_reg;
                `ASC_OFS_MODEM_CTL: reg_rdata <= modem_ctl_reg;
                `ASC_OFS_LINE_STAT: reg_rdata <= line_status;
                `ASC_OFS_MODEM_STA: reg_rdata <= {mdm_now, mdm_delta_reg};
                `ASC_OFS_DIV_LO:    reg_rdata <= div_reg[7:0];
                `ASC_OFS_DIV_HI:    reg_rdata <= div_reg[DIV_W-1:8];
                `ASC_OFS_CHAN_CFG:  reg_rdata <= channel_config_reg;
                default:            reg_rdata <= 8'h00;
            endcase
        end else
            reg_rdata <= 8'h00;
    end
endmodule
`default_nettype wire

// [asc_defs.vh]
// Register offsets, field positions and reset values of the serial channel.
`ifndef ASC_DEFS_VH
`define ASC_DEFS_VH
`define ASC_OFS_DATA      4'h0
`define ASC_OFS_IRQ_EN    4'h1
`define ASC_OFS_LINE_CTL  4'h2
`define ASC_OFS_MODEM_CTL 4'h3
`define ASC_OFS_LINE_STAT 4'h4
`define ASC_OFS_MODEM_STA 4'h5
`define ASC_OFS_DIV_LO    4'h6
`define ASC_OFS_DIV_HI    4'h7
`define ASC_OFS_CHAN_CFG  4'h8
`define ASC_LC_WLEN_LO    0
`define ASC_LC_WLEN_HI    1
`define ASC_LC_STOP2      2
`define ASC_LC_PEN        3
`define ASC_LC_EPS        4
`define ASC_LC_SP         5
`define ASC_LC_BREAK      6
`define ASC_MC_DTR        0
`define ASC_MC_RTS        1
`define ASC_MC_OUT1       2
`define ASC_MC_OUT2       3
`define ASC_MC_DIAG       4
`define ASC_CFG_INTMODEM  0
`define ASC_IE_RXDATA     0
`define ASC_IE_TXFREE     1
`define ASC_IE_LINE       2
`define ASC_IE_MODEM      3
`define ASC_LC_RST        8'h03
`define ASC_MC_RST        8'h00
`define ASC_IE_RST        8'h00
`define ASC_CFG_RST       8'h00
`define ASC_DIV_RST       16'h0001
`define ASC_TICK_LAST     4'hf
`define ASC_TICK_MID      4'h7
`endif

// [asc_baud.v]
// Baud divider producing a one-cycle tick at sixteen times the bit rate.
`timescale 1ns/1ps
`default_nettype none
module asc_baud #(
    parameter DIV_W = 16
) (
    input  wire             mclk,
    input  wire             srst,
    input  wire [DIV_W-1:0] divisor,
    output reg              tick16
);
    reg [DIV_W-1:0] cnt_reg;
    wire [DIV_W-1:0] last = divisor - {{(DIV_W-1){1'b0}}, 1'b1};

    // A divisor of zero wraps to the longest period instead of stalling.
    always @(posedge mclk) begin
        if (srst) begin
            cnt_reg <= {DIV_W{1'b0}};
            tick16  <= 1'b0;
        end else if (cnt_reg >= last) begin
            cnt_reg <= {DIV_W{1'b0}};
            tick16  <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
            tick16  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [asc_properties.sv]
// Port checker bound onto the serial channel.
`timescale 1ns/1ps
`default_nettype none
module asc_chk (
    input wire logic       mclk,
    input wire logic       srst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       serial_in,
    input wire logic       serial_out,
    input wire logic       clear_to_send_in_n,
    input wire logic       set_ready_in_n,
    input wire logic       carrier_detect_in_n,
    input wire logic       call_alert_in_n,
    input wire logic       terminal_ready_out_n,
    input wire logic       request_to_send_out_n,
    input wire logic       rx_full_dma_req,
    input wire logic       rx_full_irq_src,
    input wire logic       tx_empty_dma_req,
    input wire logic       channel_irq
);
    logic [7:0] mc_q;
    logic [7:0] ie_q;
    logic [7:0] lc_q;
    always @(posedge mclk) begin
        if (srst) begin
            mc_q <= 8'h00;
            ie_q <= 8'h00;
            lc_q <= 8'h03;
        end else if (reg_wr) begin
            if (reg_addr == 4'h3)
                mc_q <= reg_wdata;
            if (reg_addr == 4'h1)
                ie_q <= reg_wdata;
            if (reg_addr == 4'h2)
                lc_q <= reg_wdata;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    chk_reset_idle: assert property ($fell(srst) |-> serial_out
        && tx_empty_dma_req && !rx_full_irq_src && !channel_irq)
        else $error("outputs not idle after reset");
    chk_rdata_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside answer");
    chk_unmapped_rd: assert property (reg_rd && reg_addr > 4'h8
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    chk_wr_fills: assert property (reg_wr && reg_addr == 4'h0
        |=> !tx_empty_dma_req) else $error("holding still free");
    chk_hold_drains: assert property (!tx_empty_dma_req
        |-> ##[1:220] tx_empty_dma_req) else $error("holding never drained");
    chk_dma_masked: assert property (rx_full_dma_req
        |-> rx_full_irq_src) else $error("dma without full");
    chk_rd_clears: assert property (reg_rd && reg_addr == 4'h0
        |=> !rx_full_irq_src) else $error("data read left full set");
    chk_irq_masked: assert property (ie_q[3:0] == 4'h0
        |-> !channel_irq) else $error("interrupt with no enables");
    chk_rx_irq: assert property (ie_q[0] && rx_full_irq_src
        |-> channel_irq) else $error("rx full irq missing");
    chk_break_low: assert property (lc_q[6] && $past(lc_q[6])
        && !mc_q[4] && !$past(mc_q[4]) |-> !serial_out)
        else $error("break not low");
    chk_diag_high: assert property (mc_q[4] && $past(mc_q[4])
        |-> serial_out) else $error("diag output not high");
    chk_modem_outs: assert property (mc_q == $past(mc_q)
        |-> terminal_ready_out_n == (mc_q[4] | !mc_q[0])
        && request_to_send_out_n == (mc_q[4] | !mc_q[1]))
        else $error("modem outputs wrong");
endmodule
bind asc_channel asc_chk u_chk (.*);
`default_nettype wire

// [asc_remote.sv]
// Remote serial port model: frame sender, frame monitor and modem lines.
`timescale 1ns/1ps
`default_nettype none
module asc_remote (
    input  wire logic       mclk,
    input  wire logic       tx_line,
    output var  logic       rx_line,
    output var  logic [3:0] modem_n
);
    logic [3:0] nb;
    logic       parity_enable;
    logic       mon_en;
    logic       got;
    logic [9:0] got_val;
    initial begin
        rx_line = 1'b1;
        modem_n = 4'hf;
        mon_en = 1'b0;
        got = 1'b0;
        nb = 4'h8;
        parity_enable = 1'b0;
    end
    task automatic send(input logic [11:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            rx_line <= f[i];
            repeat (16) @(posedge mclk);
        end
        rx_line <= 1'b1;
        @(posedge mclk);
    endtask
    always begin : mon
        logic [9:0] v;
        @(posedge mclk);
        got <= 1'b0;
        if (mon_en && !tx_line) begin
            repeat (8) @(posedge mclk);
            v = 10'h000;
            for (int i = 0; i < nb + parity_enable + 1; i++) begin
                repeat (16) @(posedge mclk);
                v[i] = tx_line;
            end
            got_val <= v;
            got <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking testbench for the serial channel.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       mclk;
    logic       srst;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    wire  [7:0] reg_rdata;
    wire        sin;
    wire        sout;
    wire  [3:0] modem_n;
    wire        dma_rx;
    wire        irq_rx;
    wire        irq;
    logic       rd_d;
    int         seed;
    int         n_fail;
    int         checks_done;
    logic [9:0] rd_q[$];
    logic [9:0] tx_q[$];
    logic [7:0] tl[6] = '{8'h00, 8'h19, 8'h0e, 8'h2b, 8'h3b, 8'h23};
    logic [7:0] rl[6] = '{8'h1b, 8'h1b, 8'h0a, 8'h2b, 8'h2b, 8'h03};
    logic [1:0] rk[6] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h0, 2'h3};
    logic [7:0] rs[6] = '{8'h61, 8'h65, 8'h69, 8'h65, 8'h61, 8'h79};
    asc_channel dut_u (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .serial_in(sin),
        .serial_out(sout), .clear_to_send_in_n(modem_n[0]),
        .set_ready_in_n(modem_n[1]), .call_alert_in_n(modem_n[2]),
        .carrier_detect_in_n(modem_n[3]), .terminal_ready_out_n(),
        .request_to_send_out_n(), .rx_full_dma_req(dma_rx),
        .rx_full_irq_src(irq_rx), .tx_empty_dma_req(), .channel_irq(irq));
    asc_remote u_rem (.mclk(mclk), .tx_line(sout), .rx_line(sin),
        .modem_n(modem_n));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic chk(input string s, input logic [9:0] e,
                       input logic [9:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        rd_q.push_back({2'b00, e});
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
    endtask
    function automatic logic [10:0] fr(input logic [7:0] d,
                                       input logic [7:0] lc);
        int          nb;
        logic        p;
        logic [10:0] v;
        nb = lc[1:0] + 5;
        v = 11'h7ff;
        p = !lc[4];
        for (int i = 0; i < nb; i++) begin
            v[i] = d[i];
            p = p ^ d[i];
        end
        if (lc[5])
            p = !lc[4];
        if (lc[3])
            v[nb] = p;
        return v;
    endfunction
    always @(posedge mclk) begin
        rd_d <= reg_rd;
        if (rd_d)
            chk("reg_rdata", rd_q.pop_front(), {2'b00, reg_rdata});
        if (u_rem.got)
            chk("serial frame", tx_q.pop_front(), u_rem.got_val);
    end
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        results();
    end
    initial begin
        logic [7:0]  d;
        logic [10:0] f;
        int          nb;
        int          n;
        seed = 72720;
        srst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        rd(4'h4, 8'h60);
        rd(4'h2, 8'h03);
        rd(4'h6, 8'h01);
        wr(4'h9, 8'hff);
        rd(4'h9, 8'h00);
        rd(4'h5, 8'h00);
        $display("reset test done");
        u_rem.mon_en = 1'b1;
        for (int i = 0; i < 6; i++) begin
            nb = tl[i][1:0] + 5;
            u_rem.nb = 4'(nb);
            u_rem.parity_enable = tl[i][3];
            wr(4'h2, tl[i]);
            for (int k = 0; k < 2; k++) begin
                d = $random(seed);
                f = fr(d, tl[i]) & ((11'h001 << (nb + tl[i][3] + 1)) - 1);
                tx_q.push_back(f[9:0]);
                wr(4'h0, d);
            end
            rd(4'h4, 8'h00);
            repeat (384) @(posedge mclk);
            rd(4'h4, 8'h60);
        end
        $display("transmit test done");
        wr(4'h1, 8'h01);
        for (int i = 0; i < 6; i++) begin
            wr(4'h2, rl[i]);
            nb = rl[i][1:0] + 5;
            n = nb + rl[i][3] + 1 + rl[i][2];
            d = $random(seed);
            f = fr(d, rl[i]);
            if (rk[i] == 2'h1)
                f[nb] = !f[nb];
            if (rk[i] == 2'h2)
                f[nb + rl[i][3]] = 1'b0;
            if (rk[i] == 2'h3)
                f = 11'h000;
            u_rem.send({f, 1'b0}, n + 1);
            repeat (4) @(posedge mclk);
            chk("rx_full_dma_req", {9'h000, rk[i] == 2'h0}, {9'h000, dma_rx});
            chk("channel_irq", 10'h001, {9'h000, irq});
            rd(4'h4, rs[i]);
            rd(4'h0, rk[i] == 2'h3 ? 8'h00 : d & ((8'h01 << nb) - 1));
        end
        wr(4'h1, 8'h00);
        wr(4'h2, 8'h03);
        for (int k = 0; k < 2; k++) begin
            d = $random(seed);
            u_rem.send({3'b011, d, 1'b0}, 10);
        end
        repeat (4) @(posedge mclk);
        rd(4'h0, d);
        rd(4'h4, 8'h62);
        rd(4'h4, 8'h60);
        $display("receive test done");
        u_rem.mon_en = 1'b0;
        wr(4'h2, 8'h43);
        repeat (200) @(posedge mclk);
        chk("serial_out", 10'h000, {9'h000, sout});
        wr(4'h2, 8'h03);
        wr(4'h3, 8'h10);
        d = $random(seed);
        wr(4'h0, d);
        repeat (200) @(posedge mclk);
        rd(4'h0, d);
        wr(4'h3, 8'h00);
        $display("break and loop test done");
        wr(4'h8, 8'h01);
        wr(4'h3, 8'h03);
        rd(4'h5, 8'hbb);
        rd(4'h5, 8'hb0);
        u_rem.modem_n <= 4'he;
        wr(4'h8, 8'h00);
        rd(4'h5, 8'h1a);
        wr(4'h3, 8'h00);
        $display("modem test done");
        results();
    end
endmodule
`default_nettype wire
